// ==== acsc_defines.vh ====
// constants for the converter cycle and serial control block
`ifndef ACSC_DEFINES_VH
`define ACSC_DEFINES_VH
`define ACSC_CONV_TIME_US 16600
`define ACSC_CLK_MHZ 100
`define ACSC_CONV_CYCLES (`ACSC_CONV_TIME_US * `ACSC_CLK_MHZ)
`define ACSC_POR_TIME_US 500
`define ACSC_POR_CYCLES (`ACSC_POR_TIME_US * `ACSC_CLK_MHZ)
`define ACSC_RESULT_BITS 16
`define ACSC_PROG_BITS 4
`define ACSC_RATE_RESET 1'h0
`define ACSC_SLEEP_RESET 1'h0
`define ACSC_KEY_FIRST 1'h1
`define ACSC_KEY_SECOND 1'h0
`endif

// ==== acsc_sync.v ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module acsc_sync #(
	parameter RESET_VAL = 1'b0
) (
	// clock and reset
	input wire i_sys_clk,
	input wire i_rst_b,
	// data
	input wire i_d,
	output reg o_q
);
	reg meta_q;
	always @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			meta_q <= RESET_VAL;
			o_q <= RESET_VAL;
		end else begin
			meta_q <= i_d;
			o_q <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ==== acsc_top.v ====
// converter cycle state machine and serial port
`timescale 1ns/10ps
`default_nettype none
`include "acsc_defines.vh"
module acsc_top #(
	parameter CONV_CYCLES = `ACSC_CONV_CYCLES,
	parameter POR_CYCLES = `ACSC_POR_CYCLES,
	parameter SINGLE_ENDED = 1'b1
) (
	// clock and reset
	input wire i_sys_clk,
	input wire i_rst_b,
	// serial pins
	input wire i_cs_b,
	input wire i_sck,
	input wire i_sdi,
	output reg o_sdo,
	output reg o_sdo_oe,
	// converter core
	input wire [15:0] i_conv_data,
	input wire i_conv_valid,
	output reg o_conv_ready,
	output reg o_conv_start,
	output reg o_ref_power,
	output reg o_rate_30hz,
	output reg o_offset_cal,
	output reg [1:0] o_state
);
	// ----------------------------------------
	// states
	// ----------------------------------------
	localparam [3:0] ST_POR = 4'h1;
	localparam [3:0] ST_CONV = 4'h2;
	localparam [3:0] ST_NAP = 4'h4;
	localparam [3:0] ST_IO = 4'h8;
	localparam CW = 32;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	wire cs_b_s;
	wire sck_s;
	wire sdi_s;
	acsc_sync #(.RESET_VAL(1'b1)) u_cs (
		.i_sys_clk(i_sys_clk),
		.i_rst_b(i_rst_b),
		.i_d(i_cs_b),
		.o_q(cs_b_s)
	);
	acsc_sync #(.RESET_VAL(1'b0)) u_sck (
		.i_sys_clk(i_sys_clk),
		.i_rst_b(i_rst_b),
		.i_d(i_sck),
		.o_q(sck_s)
	);
	acsc_sync #(.RESET_VAL(1'b0)) u_sdi (
		.i_sys_clk(i_sys_clk),
		.i_rst_b(i_rst_b),
		.i_d(i_sdi),
		.o_q(sdi_s)
	);

	reg cs_prev_q;
	reg sck_prev_q;
	always @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cs_prev_q <= 1'b1;
			sck_prev_q <= 1'b0;
		end else begin
			cs_prev_q <= cs_b_s;
			sck_prev_q <= sck_s;
		end
	end
	wire cs_rise = cs_b_s & ~cs_prev_q;
	wire sck_rise = sck_s & ~sck_prev_q;
	wire sck_fall = ~sck_s & sck_prev_q;

	// ----------------------------------------
	// two-entry result buffer
	// ----------------------------------------
	// the core may finish while io is still busy with an abort; buffering
	// keeps the word until the holding register takes it
	reg [15:0] buf_q [0:1];
	reg wr_ptr_q;
	reg rd_ptr_q;
	reg [1:0] cnt_q;
	wire buf_valid = (cnt_q != 2'h0);
	reg [3:0] state_q;
	wire buf_pop = buf_valid & (state_q == ST_CONV);
	wire buf_push = i_conv_valid & o_conv_ready;
	// ready is registered from the next count so the port comes from a flop
	wire [1:0] cnt_d = cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
	always @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			cnt_q <= 2'h0;
			o_conv_ready <= 1'b1;
			buf_q[0] <= 16'h0000;
			buf_q[1] <= 16'h0000;
		end else begin
			if (buf_push) begin
				buf_q[wr_ptr_q] <= i_conv_data;
				wr_ptr_q <= ~wr_ptr_q;
			end
			if (buf_pop) begin
				rd_ptr_q <= ~rd_ptr_q;
			end
			cnt_q <= cnt_d;
			o_conv_ready <= (cnt_d != 2'h2);
		end
	end

	// ----------------------------------------
	// cycle state machine
	// ----------------------------------------
	reg [CW-1:0] timer_q;
	reg [15:0] hold_q;
	reg [15:0] shift_q;
	reg [4:0] fall_cnt_q;
	reg [4:0] rise_cnt_q;
	reg [3:0] prog_q;
	reg rate_q;
	reg sleep_q;
	reg sleep_arm_q;
	reg conv_done_q;
	reg sdi_all_hi_q;
	reg sdi_all_lo_q;

	always @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_q <= ST_POR;
			timer_q <= {CW{1'b0}};
			hold_q <= 16'h0000;
			shift_q <= 16'h0000;
			fall_cnt_q <= 5'h00;
			rise_cnt_q <= 5'h00;
			prog_q <= 4'h0;
			rate_q <= `ACSC_RATE_RESET;
			sleep_q <= `ACSC_SLEEP_RESET;
			sleep_arm_q <= 1'b0;
			conv_done_q <= 1'b0;
			sdi_all_hi_q <= 1'b1;
			sdi_all_lo_q <= 1'b1;
			o_conv_start <= 1'b0;
			o_ref_power <= 1'b1;
		end else begin
			o_conv_start <= 1'b0;
			case (state_q)
			ST_POR: begin
				if (timer_q >= POR_CYCLES - 1) begin
					timer_q <= {CW{1'b0}};
					state_q <= ST_CONV;
					o_conv_start <= 1'b1;
				end else begin
					timer_q <= timer_q + 1'b1;
				end
			end
			ST_CONV: begin
				// no serial event is looked at here
				if (buf_pop) begin
					hold_q <= buf_q[rd_ptr_q];
					conv_done_q <= 1'b1;
				end
				if (timer_q >= CONV_CYCLES - 1) begin
					timer_q <= {CW{1'b0}};
					state_q <= ST_NAP;
					if (sleep_arm_q) begin
						o_ref_power <= 1'b0;
					end
				end else begin
					timer_q <= timer_q + 1'b1;
				end
			end
			ST_NAP: begin
				if (!cs_b_s) begin
					state_q <= ST_IO;
					o_ref_power <= 1'b1;
					shift_q <= hold_q;
					fall_cnt_q <= 5'h00;
					rise_cnt_q <= 5'h00;
					prog_q <= 4'h0;
					sdi_all_hi_q <= 1'b1;
					sdi_all_lo_q <= 1'b1;
				end
			end
			ST_IO: begin
				if (cs_rise) begin
					state_q <= ST_CONV;
					o_conv_start <= 1'b1;
					sleep_arm_q <= sleep_q & ~(sdi_all_hi_q | sdi_all_lo_q);
					conv_done_q <= 1'b0;
				end else if (!cs_b_s) begin
					if (sck_rise) begin
						if (rise_cnt_q < `ACSC_PROG_BITS) begin
							prog_q <= {prog_q[2:0], sdi_s};
						end
						if (rise_cnt_q == `ACSC_PROG_BITS - 1) begin
							if (prog_q[2] == `ACSC_KEY_FIRST && prog_q[1] == `ACSC_KEY_SECOND) begin
								rate_q <= prog_q[0];
								sleep_q <= sdi_s;
							end
						end
						if (rise_cnt_q < `ACSC_RESULT_BITS) begin
							rise_cnt_q <= rise_cnt_q + 1'b1;
						end
						if (sdi_s) begin
							sdi_all_lo_q <= 1'b0;
						end else begin
							sdi_all_hi_q <= 1'b0;
						end
					end
					if (sck_fall) begin
						shift_q <= {shift_q[14:0], 1'b0};
						if (fall_cnt_q == `ACSC_RESULT_BITS - 1) begin
							// a whole frame of one level means a tied line
							if (sdi_all_hi_q) begin
								rate_q <= 1'b1;
							end else if (sdi_all_lo_q) begin
								rate_q <= 1'b0;
							end
							state_q <= ST_CONV;
							o_conv_start <= 1'b1;
							sleep_arm_q <= sleep_q & ~(sdi_all_hi_q | sdi_all_lo_q);
							conv_done_q <= 1'b0;
						end
						fall_cnt_q <= fall_cnt_q + 1'b1;
					end
				end
			end
			default: begin
				state_q <= ST_POR;
				timer_q <= {CW{1'b0}};
			end
			endcase
		end
	end

	// ----------------------------------------
	// pin outputs
	// ----------------------------------------
	// tied sdi looks constant; a tied-high line forces the slow rate when SINGLE_ENDED is set
	always @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_sdo <= 1'b0;
			o_sdo_oe <= 1'b0;
			o_rate_30hz <= 1'b0;
			o_offset_cal <= 1'b0;
			o_state <= 2'h0;
		end else begin
			o_sdo_oe <= ~cs_b_s;
			if (state_q == ST_IO) begin
				o_sdo <= shift_q[15];
			end else begin
				o_sdo <= (state_q != ST_NAP);
			end
			o_rate_30hz <= SINGLE_ENDED & rate_q;
			o_offset_cal <= ~SINGLE_ENDED | rate_q;
			case (state_q)
			ST_CONV: o_state <= 2'h1;
			ST_NAP: o_state <= 2'h2;
			ST_IO: o_state <= 2'h3;
			default: o_state <= 2'h0;
			endcase
		end
	end
endmodule
`default_nettype wire

// ==== acsc_top_monitor.sv ====
// checker for the converter cycle and serial control block
`timescale 1ns/10ps
`default_nettype none
module acsc_mon #(
	parameter SINGLE_ENDED = 1'b1
) (
	// clock and pins
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_cs_b,
	input wire logic i_sck,
	// outputs
	input wire logic o_sdo,
	input wire logic o_sdo_oe,
	input wire logic o_ref_power,
	input wire logic o_rate_30hz,
	input wire logic o_offset_cal,
	input wire logic [1:0] o_state
);
	// ----
	// properties; pin delays allow for the synchronisers
	// ----
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);
	property p_hold; $rose(o_state==2'h1) |-> (o_state==2'h1) [*8]; endproperty
	a_hold: assert property (p_hold) else $error("convert cut short");
	property p_nap; i_cs_b [*5] ##0 o_state==2'h2 |=> o_state==2'h2; endproperty
	a_nap: assert property (p_nap) else $error("left nap");
	property p_off; i_cs_b [*5] |-> !o_sdo_oe; endproperty
	a_off: assert property (p_off) else $error("output on");
	property p_io; o_state==2'h3 |=> o_state==2'h3 || o_state==2'h1; endproperty
	a_io: assert property (p_io) else $error("bad io exit");
	property p_abort; o_state==2'h3 && $rose(i_cs_b) |-> ##[1:6] o_state==2'h1; endproperty
	a_abort: assert property (p_abort) else $error("abort missed");
	property p_stat; (!i_cs_b && i_sck) [*6] ##0 o_state==2'h1 |-> o_sdo && o_sdo_oe; endproperty
	a_stat: assert property (p_stat) else $error("no busy status");
	property p_ref; $rose(o_state==2'h3) |-> ##[0:2] o_ref_power; endproperty
	a_ref: assert property (p_ref) else $error("reference asleep");
	property p_rate; !SINGLE_ENDED || o_offset_cal==o_rate_30hz; endproperty
	a_rate: assert property (p_rate) else $error("rate mismatch");
endmodule
bind acsc_top acsc_mon #(.SINGLE_ENDED(SINGLE_ENDED)) u_mon (.i_sys_clk(i_sys_clk),
	.i_rst_b(i_rst_b), .i_cs_b(i_cs_b), .i_sck(i_sck), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe),
	.o_ref_power(o_ref_power), .o_rate_30hz(o_rate_30hz), .o_offset_cal(o_offset_cal),
	.o_state(o_state));
`default_nettype wire

// ==== acsc_host.sv ====
// host model on the serial pins
`timescale 1ns/10ps
`default_nettype none
module acsc_host (
	// clock and pins
	input wire logic i_sys_clk,
	input wire logic i_sdo,
	output logic o_cs_b = 1'b1,
	output logic o_sck = 1'b0,
	output logic o_sdi = 1'b0
);
	// ----
	// frames: sck idles low except in status, which holds it high; 40 ns a phase
	// ----
	task automatic xfer(input logic [3:0] p, input int nb, input logic [11:0] t,
		output logic [15:0] rd);
		@(posedge i_sys_clk) o_cs_b <= 1'b0;
		rd = 16'h0000;
		repeat (8) @(posedge i_sys_clk);
		for (int i = 15; i > 15 - nb; i--) begin
			o_sck <= 1'b0;
			o_sdi <= i > 11 ? p[i - 12] : t[i];
			repeat (4) @(posedge i_sys_clk);
			o_sck <= 1'b1;
			repeat (4) @(posedge i_sys_clk);
			rd[i] = i_sdo;
		end
		o_sck <= 1'b0;
		// released data line flips so a stale level is never mistaken for data
		o_sdi <= ~o_sdi;
		repeat (8) @(posedge i_sys_clk);
		o_cs_b <= 1'b1;
	endtask
	task automatic status(output logic s);
		@(posedge i_sys_clk) o_sck <= 1'b1;
		@(posedge i_sys_clk) o_cs_b <= 1'b0;
		repeat (8) @(posedge i_sys_clk);
		s = i_sdo;
		o_cs_b <= 1'b1;
		repeat (8) @(posedge i_sys_clk);
		o_sck <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== acsc_top_tb_top.sv ====
// bench for the converter cycle and serial control block
`timescale 1ns/10ps
`default_nettype none
module acsc_top_tb_top;
	logic i_sys_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic i_conv_valid = 1'b0;
	logic [15:0] i_conv_data = 16'h0000;
	logic cs_b, sck, sdi, sdo, oe, rdy, start, refp, rate, ofs, s;
	logic rt = 1'b0;
	logic sl = 1'b0;
	logic [1:0] st;
	logic [15:0] rd, e, last_w;
	logic [31:0] lf = 32'h5B785CE5;
	logic [3:0] pw [7] = '{4'hB, 4'h3, 4'h8, 4'hA, 4'h7, 4'h9, 4'hF};
	int num_errors = 0;
	int checks_done = 0;
	int cyc = 0;
	acsc_top #(.CONV_CYCLES(200), .POR_CYCLES(20)) dut (.i_sys_clk(i_sys_clk),
		.i_rst_b(i_rst_b), .i_cs_b(cs_b), .i_sck(sck), .i_sdi(sdi), .o_sdo(sdo),
		.o_sdo_oe(oe), .i_conv_data(i_conv_data), .i_conv_valid(i_conv_valid),
		.o_conv_ready(rdy), .o_conv_start(start), .o_ref_power(refp),
		.o_rate_30hz(rate), .o_offset_cal(ofs), .o_state(st));
	acsc_host host (.i_sys_clk(i_sys_clk), .i_sdo(sdo), .o_cs_b(cs_b), .o_sck(sck),
		.o_sdi(sdi));
	initial forever #5 i_sys_clk = ~i_sys_clk;
	function automatic logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic chk(input logic ok, input string m);
		checks_done++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask
	task automatic wait_st(input logic [1:0] v);
		int n;
		n = 0;
		while (st !== v && n < 900) begin
			@(posedge i_sys_clk);
			n++;
		end
		chk(n < 900, "state wait");
	endtask
	task automatic results();
		$display("%0d checks, %0d mismatches", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// ----
	// core side: one word per conversion, held until taken
	// ----
	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			results();
		end
		if (i_conv_valid && rdy) i_conv_valid <= 1'b0;
		else if (start) begin
			lf = nx(lf);
			i_conv_data <= lf[15:0];
			i_conv_valid <= 1'b1;
			last_w = lf[15:0];
		end
	end
	initial begin
		repeat (16) @(posedge i_sys_clk);
		i_rst_b <= 1'b1;
		wait_st(2'h2);
		host.xfer(4'h0, 16, 12'h000, rd);
		foreach (pw[k]) begin
			wait_st(2'h2);
			e = last_w;
			host.xfer(pw[k], 16, lf[27:16], rd);
			chk(rd === e, "read word");
			if (pw[k][3:2] == 2'b10) {rt, sl} = pw[k][1:0];
			wait_st(2'h2);
			chk(rate === rt && refp === !sl, "settings");
			$display("word %h done", pw[k]);
		end
		wait_st(2'h2);
		e = last_w;
		host.xfer(4'hF, 16, 12'hFFF, rd);
		chk(rd === e, "tied read");
		rt = 1'b1;
		wait_st(2'h2);
		chk(rate === rt && refp === 1'b1, "tied high");
		$display("tied input done");
		wait_st(2'h2);
		e = last_w;
		host.xfer(4'h0, 7, 12'h000, rd);
		chk(rd[15:9] === e[15:9], "partial read");
		repeat (8) @(posedge i_sys_clk);
		chk(st === 2'h1, "abort");
		host.status(s);
		chk(s === 1'b1 && st === 2'h1, "busy status");
		wait_st(2'h2);
		e = last_w;
		host.xfer(4'h8, 16, 12'hFFF, rd);
		chk(rd === e, "read after abort");
		$display("abort and status done");
		results();
	end
endmodule
`default_nettype wire
